// *** src/adcc_defines.svh ***
// adcc_defines.svh: addresses, bit positions, reset values and counts
// assumes: included by bare name from every adcc source file
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// register addresses on the special function bus
`define ADCC_CTRL_ADDR     8'hE1
`define ADCC_RESH_ADDR     8'hE2
`define ADCC_IST_ADDR      8'hE3
`define ADCC_IMSK_ADDR     8'hE4
`define ADCC_P0OFF_ADDR    8'hF6

// control register bit positions
`define ADCC_B_RES1        7
`define ADCC_B_RES0        6
`define ADCC_B_EXTEN       5
`define ADCC_B_DONE        4
`define ADCC_B_START       3
`define ADCC_B_RCSEL       2
`define ADCC_B_CHHI        1
`define ADCC_B_CHLO        0

// interrupt status and mask bit positions
`define ADCC_I_DONE        0
`define ADCC_I_ABORT       1

// reset values
`define ADCC_ZERO8         8'h00
`define ADCC_ZERO10        10'h000
`define ADCC_ZERO4         4'h0
`define ADCC_ZERO2         2'h0
`define ADCC_ONE10         10'h001
`define ADCC_ONE8          8'h01

// port 0 bit that carries analog input zero
`define ADCC_AIN_BASE      3'h3

// timing: cpu clock and converter step rate
`define ADCC_CLK_HZ        10000000
`define ADCC_STEP_HZ       2500000
`define ADCC_DIV_LAST      4'((`ADCC_CLK_HZ / `ADCC_STEP_HZ) - 1)
`define ADCC_SAMPLE_LAST   4'h3
`define ADCC_MSB_IDX       4'h9
`define ADCC_ONE4          4'h1

`endif

// *** src/adcc_pkg.sv ***
// adcc_pkg: types and helpers shared by the converter control files
// assumes: adcc_defines.svh is on the include path
`default_nettype none
`include "adcc_defines.svh"

package adcc_pkg;

    // converter engine states, gray along idle-sample-convert-finish
    typedef enum logic [1:0] {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONV   = 2'b11,
        ADCC_FINISH = 2'b10
    } adcc_state_e;

    // result handed from the engine to the register file
    typedef struct packed {
        logic [9:0] code;  // full 10-bit result
        logic       fin;   // one-cycle pulse: result valid
    } adcc_result_s;

    // address match on the register bus
    function automatic logic adcc_hit(input logic [7:0] addr, input logic [7:0] target);
        adcc_hit = (addr == target);
    endfunction : adcc_hit

    // channel number to one-hot port 0 bit
    function automatic logic [7:0] adcc_ain_onehot(input logic [1:0] chan);
        adcc_ain_onehot = `ADCC_ONE8 << (`ADCC_AIN_BASE + 3'(chan));
    endfunction : adcc_ain_onehot

endpackage : adcc_pkg
`default_nettype wire

// *** src/adcc_sar.sv ***
// adcc_sar: successive approximation sequencer for the 10-bit converter
// assumes: start only arrives when idle; tick is a one-cycle step enable
`default_nettype none
`include "adcc_defines.svh"

module adcc_sar
    import adcc_pkg::*;
(
    input  wire logic       clk,       // cpu clock
    input  wire logic       rst_n,     // synchronised reset, active low
    input  wire logic       tick,      // step enable from divider
    input  wire logic       start,     // accepted start, one cycle
    input  wire logic       abort,     // software abort, one cycle
    input  wire logic       comp_in,   // comparator: input above dac
    output var  logic [9:0] dac_code,  // trial code to the dac
    output var  logic       active,    // engine not idle
    output var  adcc_result_s result   // result and finish pulse
);

    adcc_state_e state;     // engine state
    logic [3:0]  bit_idx;   // bit under trial
    logic [3:0]  samp_cnt;  // sample phase step count

    // trial code with the current bit kept or dropped by the comparator
    wire logic [9:0] bit_mask  = `ADCC_ONE10 << bit_idx;
    wire logic [9:0] kept_code = comp_in ? dac_code : (dac_code & ~bit_mask);
    wire logic [9:0] next_code = kept_code | (`ADCC_ONE10 << (bit_idx - `ADCC_ONE4));
    wire logic       last_bit  = (bit_idx == `ADCC_ZERO4);

    // sequencer; abort wins over every state so a cleared start stops at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ADCC_IDLE;
            bit_idx    <= `ADCC_ZERO4;
            samp_cnt   <= `ADCC_ZERO4;
            dac_code   <= `ADCC_ZERO10;
            result     <= '0;
        end else begin
            result.fin <= 1'b0;  // finish is a pulse
            if (abort) begin
                state    <= ADCC_IDLE;
                dac_code <= `ADCC_ZERO10;
            end else begin
                case (state)
                    ADCC_IDLE: begin
                        if (start) begin
                            state    <= ADCC_SAMPLE;
                            samp_cnt <= `ADCC_ZERO4;
                        end
                    end
                    ADCC_SAMPLE: begin
                        // hold the input for a few steps before trials
                        if (tick) begin
                            if (samp_cnt == `ADCC_SAMPLE_LAST) begin
                                state    <= ADCC_CONV;
                                bit_idx  <= `ADCC_MSB_IDX;
                                dac_code <= `ADCC_ONE10 << `ADCC_MSB_IDX;
                            end else begin
                                samp_cnt <= samp_cnt + `ADCC_ONE4;
                            end
                        end
                    end
                    ADCC_CONV: begin
                        // one bit decided per step, msb first
                        if (tick) begin
                            if (last_bit) begin
                                dac_code <= kept_code;
                                state    <= ADCC_FINISH;
                            end else begin
                                dac_code <= next_code;
                                bit_idx  <= bit_idx - `ADCC_ONE4;
                            end
                        end
                    end
                    ADCC_FINISH: begin
                        result.code <= dac_code;
                        result.fin  <= 1'b1;
                        state       <= ADCC_IDLE;
                    end
                    default: begin
                        state <= ADCC_IDLE;
                    end
                endcase
            end
        end
    end

    assign active = (state != ADCC_IDLE);

endmodule : adcc_sar
`default_nettype wire

// *** src/adcc_top.sv ***
// adcc_top: conversion control, result and port 0 input-off registers
// assumes: cpu drives the register port synchronously; comparator and
// dac of the analog converter sit outside and see DAC_CODE / COMP_IN
//
// What this block does
// - both flags zero: idle, start accepted
// - busy without done: further starts ignored
// - done set: starts refused until cleared
// - both set briefly while finishing; harmless
// - channel select written only while idle
// - channels 0-3 map to port0 bits 3-6
// - result bits 9:2 readable at E2h
// - F6h bits switch off port0 input buffers
// - start bit held while busy, then cleared
// - done set by hardware, raises interrupt
// - clearing start mid-conversion aborts it
// - enabled external rising edge also starts
`default_nettype none
`include "adcc_defines.svh"

module adcc_top
    import adcc_pkg::*;
(
    input  wire logic       CLOCK,          // cpu clock, 10 MHz
    input  wire logic       ARST_N,         // async reset, active low
    input  wire logic [7:0] ADDR,           // register address
    input  wire logic [7:0] WDATA,          // write data
    input  wire logic       WR_STB,         // write strobe, one cycle
    input  wire logic       RD_STB,         // read strobe, one cycle
    output var  logic [7:0] RDATA,          // read data, cycle after strobe
    input  wire logic       EXT_START_PIN,  // external start trigger
    input  wire logic       COMP_IN,        // comparator result
    output var  logic [9:0] DAC_CODE,       // trial code to the dac
    output var  logic       CONV_ACTIVE,    // engine sampling, converting or finishing
    output var  logic [7:0] ANALOG_SEL,     // one-hot port 0 analog switch
    output var  logic [7:0] DIGITAL_IN_OFF, // port 0 input buffer off
    output var  logic       IRQ             // level interrupt, active high
);

    // reset release through two flops
    logic rst_meta;  // first stage, read only by rst_n
    logic rst_n;     // released reset used by the whole block

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // control and data state
    logic       ext_trigger_enable;   // pin may start conversions
    logic       conv_done_flag;       // result ready
    logic       conv_start_busy;      // start request / busy status
    logic       clk_src_sel;          // stored only; engine runs on cpu clock
    logic       channel_sel_hi;       // channel select, upper bit
    logic       channel_sel_lo;       // channel select, lower bit
    logic [1:0] result_low;           // result bits 1:0
    logic [7:0] result_high_reg;      // result bits 9:2
    logic [7:0] port0_input_off_reg;  // digital input off per pin
    logic [1:0] irq_status;           // sticky events
    logic [1:0] irq_mask;             // event enables
    logic       ext_prev;             // last sampled pin level
    logic       fin_d;                // finish pulse delayed one cycle
    logic [3:0] div_cnt;              // step divider
    adcc_result_s eng_result;         // engine result carrier

    // register decode
    wire logic hit_ctrl  = adcc_hit(ADDR, `ADCC_CTRL_ADDR);
    wire logic hit_resh  = adcc_hit(ADDR, `ADCC_RESH_ADDR);
    wire logic hit_ist   = adcc_hit(ADDR, `ADCC_IST_ADDR);
    wire logic hit_imsk  = adcc_hit(ADDR, `ADCC_IMSK_ADDR);
    wire logic hit_p0off = adcc_hit(ADDR, `ADCC_P0OFF_ADDR);
    wire logic wr_ctrl   = WR_STB & hit_ctrl;
    wire logic wr_ist    = WR_STB & hit_ist;
    wire logic wr_imsk   = WR_STB & hit_imsk;
    wire logic wr_p0off  = WR_STB & hit_p0off;

    // status decode
    wire logic conv_idle = ~conv_done_flag & ~conv_start_busy;
    wire logic eng_fin   = eng_result.fin;

    // software may clear done but never set it
    wire logic done_clear = wr_ctrl & ~WDATA[`ADCC_B_DONE];

    // start sources; the pin edge counts only when enabled
    wire logic sw_start = wr_ctrl & WDATA[`ADCC_B_START];
    wire logic ext_rise = ext_trigger_enable & EXT_START_PIN & ~ext_prev;

    // a start needs busy low and done low or being cleared in the same write;
    // done and start written together starts again on the old channel
    wire logic start_ok = ~conv_start_busy & (~conv_done_flag | done_clear);
    wire logic start_go = (sw_start | ext_rise) & start_ok;

    // writing start low during conversion stops the engine
    wire logic abort_go = wr_ctrl & ~WDATA[`ADCC_B_START] & conv_start_busy
                          & ~conv_done_flag;

    // done: a finishing result wins over a clear in the same cycle
    wire logic next_done = eng_fin | (conv_done_flag & ~done_clear);

    // busy stays up through the finish cycle (both flags high for one cycle),
    // and drops the cycle after done rises
    wire logic next_busy = start_go | (conv_start_busy & ~abort_go & ~fin_d);

    // channel bits move only while idle
    wire logic       chan_wr   = wr_ctrl & conv_idle;
    wire logic [1:0] cur_chan  = {channel_sel_hi, channel_sel_lo};
    wire logic [1:0] next_chan = chan_wr ? WDATA[`ADCC_B_CHHI:`ADCC_B_CHLO] : cur_chan;

    // sticky interrupt events; a new event beats a write-one clear
    wire logic [1:0] irq_event  = {abort_go, eng_fin};
    wire logic [1:0] irq_clr    = wr_ist ? WDATA[1:0] : `ADCC_ZERO2;
    wire logic [1:0] next_irq   = (irq_status & ~irq_clr) | irq_event;

    // step divider terminal count
    wire logic step_tick = (div_cnt == `ADCC_DIV_LAST);
    wire logic [3:0] next_div = step_tick ? `ADCC_ZERO4 : (div_cnt + `ADCC_ONE4);

    // control register image
    wire logic [7:0] ctrl_image = {result_low, ext_trigger_enable, conv_done_flag,
                                   conv_start_busy, clk_src_sel, channel_sel_hi,
                                   channel_sel_lo};

    // read selection; unmapped addresses read zero
    wire logic [7:0] rd_mux =
        hit_ctrl  ? ctrl_image :
        hit_resh  ? result_high_reg :
        hit_ist   ? {6'h00, irq_status} :
        hit_imsk  ? {6'h00, irq_mask} :
        hit_p0off ? port0_input_off_reg :
                    `ADCC_ZERO8;
    wire logic [7:0] next_rdata = RD_STB ? rd_mux : `ADCC_ZERO8;

    // conversion flags and channel
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            conv_done_flag  <= 1'b0;
            conv_start_busy <= 1'b0;
            channel_sel_hi  <= 1'b0;
            channel_sel_lo  <= 1'b0;
            fin_d           <= 1'b0;
        end else begin
            conv_done_flag  <= next_done;
            conv_start_busy <= next_busy;
            channel_sel_hi  <= next_chan[1];
            channel_sel_lo  <= next_chan[0];
            fin_d           <= eng_fin;
        end
    end

    // freely written control bits; these have no idle restriction
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ext_trigger_enable <= 1'b0;
            clk_src_sel        <= 1'b0;
        end else if (wr_ctrl) begin
            ext_trigger_enable <= WDATA[`ADCC_B_EXTEN];
            clk_src_sel        <= WDATA[`ADCC_B_RCSEL];
        end
    end

    // result capture in the same cycle that done rises
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            result_high_reg <= `ADCC_ZERO8;
            result_low      <= `ADCC_ZERO2;
        end else if (eng_fin) begin
            result_high_reg <= eng_result.code[9:2];
            result_low      <= eng_result.code[1:0];
        end
    end

    // port 0 digital input off register
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            port0_input_off_reg <= `ADCC_ZERO8;
        end else if (wr_p0off) begin
            port0_input_off_reg <= WDATA;
        end
    end

    // interrupt status and mask
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `ADCC_ZERO2;
            irq_mask   <= `ADCC_ZERO2;
        end else begin
            irq_status <= next_irq;
            if (wr_imsk) begin
                irq_mask <= WDATA[1:0];
            end
        end
    end

    // pin edge history and step divider
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev <= 1'b0;
            div_cnt  <= `ADCC_ZERO4;
        end else begin
            ext_prev <= EXT_START_PIN;
            div_cnt  <= next_div;
        end
    end

    // registered outputs: read data, analog switch, buffer disables
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA          <= `ADCC_ZERO8;
            ANALOG_SEL     <= `ADCC_ZERO8;
            DIGITAL_IN_OFF <= `ADCC_ZERO8;
        end else begin
            RDATA          <= next_rdata;
            ANALOG_SEL     <= adcc_ain_onehot(next_chan);
            DIGITAL_IN_OFF <= wr_p0off ? WDATA : port0_input_off_reg;
        end
    end

    // interrupt level from registered status and mask
    assign IRQ = |(irq_status & irq_mask);

    // converter engine; the analog side only sees the trial code
    adcc_sar u_sar (
        .clk      (CLOCK),
        .rst_n    (rst_n),
        .tick     (step_tick),
        .start    (start_go),
        .abort    (abort_go),
        .comp_in  (COMP_IN),
        .dac_code (DAC_CODE),
        .active   (CONV_ACTIVE),
        .result   (eng_result)
    );

endmodule : adcc_top
`default_nettype wire

// *** verif/adcc_comp_model.sv ***
// adcc_comp_model: analog inputs and comparator facing the converter
// assumes: level holds each channel's input in whole code steps
`default_nettype none

module adcc_comp_model (
    input  wire logic [7:0]      sel,    // one-hot analog switch
    input  wire logic [9:0]      dac,    // trial code
    input  wire logic [3:0][9:0] level,  // input per channel
    output var  logic            comp    // 1: input above trial
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] vin;  // level on the selected pin

    // port 0 bits 3..6 carry channels zero..three; no pin means ground
    always_comb begin
        vin = 10'h000;
        for (int i = 0; i < 4; i++)
            if (sel[i + 3]) vin = level[i];
    end
    // input sits half a step above its code, so a tie counts as above
    assign comp = (vin >= dac);
endmodule : adcc_comp_model
`default_nettype wire

// *** verif/adcc_top_chk.sv ***
// adcc_top_chk: port-level assertions for the conversion control block
// assumes: bound to adcc_top, sees only its ports, one clock domain
`default_nettype none

module adcc_top_chk (
    input wire logic       CLOCK,          // cpu clock
    input wire logic       ARST_N,         // async reset, active low
    input wire logic [7:0] ADDR,           // register address
    input wire logic [7:0] WDATA,          // write data
    input wire logic       WR_STB,         // write strobe
    input wire logic       RD_STB,         // read strobe
    input wire logic [7:0] RDATA,          // read answer
    input wire logic       EXT_START_PIN,  // external trigger
    input wire logic [9:0] DAC_CODE,       // trial code
    input wire logic       CONV_ACTIVE,    // engine busy
    input wire logic [7:0] ANALOG_SEL,     // one-hot switch
    input wire logic [7:0] DIGITAL_IN_OFF  // input buffer off
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] settle;   // edges since reset release, saturates
    logic [6:0] run_cnt;  // length of the current run
    logic       aborted;  // run cut short by software
    wire        ctrl_wr  = WR_STB && ADDR == 8'hE1;  // control write
    wire        start_wr = ctrl_wr && WDATA[3];      // software start

    // helper counters; saturate so a long hang cannot wrap back into range
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            settle  <= 3'h0;
            run_cnt <= 7'h00;
            aborted <= 1'b0;
        end else begin
            settle  <= (settle == 3'h7) ? settle : settle + 3'h1;
            run_cnt <= !CONV_ACTIVE ? 7'h00 : (run_cnt == 7'h7F) ? run_cnt : run_cnt + 7'h01;
            aborted <= CONV_ACTIVE && (aborted || (ctrl_wr && !WDATA[3]));
        end
    end

    default clocking cb_chk @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    sequence s_p0_wr;
        WR_STB && ADDR == 8'hF6 && settle == 3'h7;
    endsequence
    sequence s_abort_wr;
        ctrl_wr && !WDATA[3] && CONV_ACTIVE;
    endsequence

    property p_rd_idle;
        !RD_STB |=> RDATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_rd_hole;
        RD_STB && !(ADDR inside {8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hF6}) |=> RDATA == 8'h00;
    endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    property p_p0_rd;
        RD_STB && ADDR == 8'hF6 |=> RDATA == $past(DIGITAL_IN_OFF);
    endproperty
    a_p0_rd: assert property (p_p0_rd) else $error("input-off read differs");
    property p_p0_wr;
        s_p0_wr |=> DIGITAL_IN_OFF == $past(WDATA);
    endproperty
    a_p0_wr: assert property (p_p0_wr) else $error("input-off write lost");
    property p_p0_hold;
        !(WR_STB && ADDR == 8'hF6) |=> $stable(DIGITAL_IN_OFF);
    endproperty
    a_p0_hold: assert property (p_p0_hold) else $error("input-off changed unasked");
    property p_sel_hot;
        settle == 3'h7 |-> $onehot(ANALOG_SEL) && (ANALOG_SEL & 8'h87) == 8'h00;
    endproperty
    a_sel_hot: assert property (p_sel_hot) else $error("analog select not on bits 3-6");
    property p_sel_busy;
        $changed(ANALOG_SEL) |-> !($past(CONV_ACTIVE) && $past(CONV_ACTIVE, 2));
    endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("channel moved mid-run");
    property p_start_cause;
        $rose(CONV_ACTIVE) |-> $past(start_wr) || $past(EXT_START_PIN);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("run without a start");
    property p_abort;
        s_abort_wr |-> ##[1:2] (!CONV_ACTIVE && DAC_CODE == 10'h000);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not honoured");
    property p_run_len;
        $fell(CONV_ACTIVE) && !aborted |-> run_cnt >= 7'h32 && run_cnt <= 7'h46;
    endproperty
    a_run_len: assert property (p_run_len) else $error("run length out of range");
    property p_run_bound;
        CONV_ACTIVE |-> run_cnt <= 7'h46;
    endproperty
    a_run_bound: assert property (p_run_bound) else $error("run never ends");
endmodule : adcc_top_chk

bind adcc_top adcc_top_chk i_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .EXT_START_PIN(EXT_START_PIN),
    .DAC_CODE(DAC_CODE), .CONV_ACTIVE(CONV_ACTIVE), .ANALOG_SEL(ANALOG_SEL),
    .DIGITAL_IN_OFF(DIGITAL_IN_OFF));
`default_nettype wire

// *** verif/adcc_top_tb_top.sv ***
// adcc_top_tb_top: self-checking bench for the conversion control block
// assumes: design, checker and comparator model compiled before it
`default_nettype none

module adcc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clock, arst_n, wr_stb, rd_stb, ext_pin, comp, irq, active, rd_d;
    logic [7:0]      addr, wdata, rdata, sel, in_off;
    logic [9:0]      dac, v;     // trial code; current input level
    logic [3:0][9:0] level;      // analog level per channel
    logic [1:0]      c;          // channel under test
    logic [7:0]      exp_q[$];   // expected read answers, oldest first
    string           nm_q[$];    // what each read checks
    int              n_errors, comparisons;

    adcc_top i_dut (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RDATA(rdata), .EXT_START_PIN(ext_pin), .COMP_IN(comp), .DAC_CODE(dac),
        .CONV_ACTIVE(active), .ANALOG_SEL(sel), .DIGITAL_IN_OFF(in_off), .IRQ(irq));
    adcc_comp_model i_comp (.sel(sel), .dac(dac), .level(level), .comp(comp));

    always #50 clock = ~clock;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string name);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // one-cycle write; returns mid-cycle so the write has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        cyc(1);
    endtask : wr
    // one-cycle read; the answer is judged by the watcher below
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
        exp_q.push_back(e);
        nm_q.push_back(name);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        cyc(1);
    endtask : rd
    task automatic pulse_pin();
        @(posedge clock);
        ext_pin <= 1'b1;
        cyc(2);
        @(posedge clock);
        ext_pin <= 1'b0;
        cyc(1);
    endtask : pulse_pin
    // bounded wait for the engine to go idle
    task automatic wait_idle();
        int i;
        cyc(2);
        for (i = 0; i < 100 && active !== 1'b0; i++) cyc(1);
        if (i == 100) begin
            n_errors++;
            $display("[FAIL] idle wait expected 0 seen 1");
            stop_test();
        end else begin
            cyc(2);  // done, result and interrupt land one edge after the engine idles
        end
    endtask : wait_idle

    // answer stands only in the cycle after the strobe, so look there
    always @(posedge clock) begin
        if (rd_d) chk(10'(rdata), 10'(exp_q.pop_front()), nm_q.pop_front());
        rd_d <= rd_stb;
    end

    initial begin
        clock   = 1'b0;
        arst_n  = 1'b0;
        addr    = 8'h00;
        wdata   = 8'h00;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        ext_pin = 1'b0;
        rd_d    = 1'b0;
        level   = '0;
        void'($urandom(46500));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        cyc(1);
        // reset values, hole, read-only result, input-off register
        chk(10'(sel), 10'h008, "sel");
        rd(8'hF6, 8'h00, "p0 reset");
        rd(8'hE1, 8'h00, "ctrl reset");
        rd(8'hE0, 8'h00, "hole");
        v = 10'($urandom);
        wr(8'hF6, v[7:0]);
        chk(10'(in_off), 10'(v[7:0]), "in_off");
        rd(8'hF6, v[7:0], "p0 back");
        wr(8'hE2, 8'h5A);
        rd(8'hE2, 8'h00, "result ro");
        $display("test regs done");
        wr(8'hE4, 8'h01);
        // one conversion per channel, then starts refused while done
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            v = 10'($urandom);
            level[c] = v;
            wr(8'hE1, {6'h00, c});
            cyc(1);
            chk(10'(sel), 10'(8'h08 << c), "sel");
            wr(8'hE1, {4'h0, 2'b10, c});
            wait_idle();
            chk(10'(irq), 10'h001, "irq done");
            rd(8'hE2, v[9:2], "result high");
            rd(8'hE1, {v[1:0], 4'b0100, c}, "ctrl done");
            wr(8'hE1, {4'b0001, 2'b10, ~c});
            cyc(2);
            chk(10'(active), 10'h000, "start refused");
            chk(10'(sel), 10'(8'h08 << c), "sel held");
            wr(8'hE3, 8'h01);
            chk(10'(irq), 10'h000, "irq clear");
            wr(8'hE1, {6'h00, c});
            rd(8'hE1, {v[1:0], 4'h0, c}, "ctrl cleared");
        end
        $display("test channels done");
        // restart ignored while busy, then software abort
        wr(8'hE1, 8'h0B);
        cyc(10);
        chk(10'(active), 10'h001, "busy");
        wr(8'hE1, 8'h09);
        chk(10'(sel), 10'h040, "sel busy");
        chk(10'(active), 10'h001, "still busy");
        wr(8'hE1, 8'h03);
        cyc(1);
        chk(10'(active), 10'h000, "aborted");
        chk(dac, 10'h000, "dac idle");
        chk(10'(irq), 10'h000, "abort masked");
        rd(8'hE3, 8'h02, "abort event");
        rd(8'hE1, {v[1:0], 4'h0, 2'h3}, "no done");
        wr(8'hE3, 8'h02);
        $display("test abort done");
        // external trigger off then on, interrupt masked then unmasked
        v = 10'($urandom);
        level[3] = v;
        wr(8'hE4, 8'h00);
        pulse_pin();
        cyc(2);
        chk(10'(active), 10'h000, "ext off");
        // clock source bit set here too: stored and read back, no effect
        wr(8'hE1, 8'h27);
        pulse_pin();
        chk(10'(active), 10'h001, "ext start");
        wait_idle();
        chk(10'(irq), 10'h000, "irq masked");
        rd(8'hE3, 8'h01, "done event");
        wr(8'hE4, 8'h01);
        chk(10'(irq), 10'h001, "irq unmasked");
        wr(8'hE3, 8'h01);
        chk(10'(irq), 10'h000, "irq cleared");
        rd(8'hE2, v[9:2], "ext result");
        rd(8'hE1, {v[1:0], 4'b1101, 2'h3}, "ext ctrl");
        $display("test ext trigger done");
        cyc(3);
        stop_test();
    end
endmodule : adcc_top_tb_top
`default_nettype wire
